/* File: gps_pkg.sv */
// Behaviour
// - pci mode offers 4-bit input port on local data lines, other peripheral uses off.
// - trigger write captures local data 7-4 into port data bits 7-4 two display clocks later.
// - trigger write drives port data low nibble out, pulses strobe, samples on rising edge.
// - select field 01 enables write strobe on pci, port strobe on local bus.
// - pci mode offers 4-bit output port from port data low nibble.
// - strobe rises two display clocks after assertion; data held half display clock after.
// - pci select bit 1 drives output register bits 1-0 statically on two pins.
// - local bus select 11 drives output bits 1-0 on two pins, replacing rom select.
// - local bus select 10 drives only output bit 0, rom chip select kept.
// - local bus output register write appears at once on upper data byte with strobe.
// - local bus output cycle completes in about six to eight system clocks.
// - input enable bit 2 lets a read of port 3c8 return external byte.
// - local bus input cycle takes about eighteen to twenty system clocks.
// - at power-up with select 00 both dedicated pins are driven high.
package gps_pkg;
  localparam logic [1:0]  GPS_SEL_STROBE    = 2'h1;
  localparam logic [1:0]  GPS_SEL_OUT1      = 2'h2;
  localparam logic [1:0]  GPS_SEL_OUT2      = 2'h3;
  localparam int          GPS_SEL_PCI_BIT   = 1;
  localparam int          GPS_IN_EN_BIT     = 2;
  localparam logic [15:0] GPS_INPUT_PORT    = 16'h03C8;
  localparam logic [7:0]  GPS_DATA_RST      = 8'h00;
  localparam logic [7:0]  GPS_OUT_RST       = 8'h00;
  localparam int          GPS_DISP_DIV      = 2;
  localparam int          GPS_STROBE_TICKS  = 2;
  localparam int          GPS_OUT_SCLKS     = 7;
  localparam int          GPS_IN_SCLKS      = 19;
  typedef enum logic [1:0] {
    GPS_IDLE  = 2'b00,
    GPS_PCI   = 2'b01,
    GPS_HOLD  = 2'b10,
    GPS_LOCAL = 2'b11
  } gps_state_e;
endpackage

/* File: gps_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface gps_if;
  logic       tick;
  logic [4:0] count;
  logic       start;
  logic       clear;
  modport owner (output start, output clear, input tick, input count);
  modport timer (input start, input clear, output tick, output count);
endinterface
`default_nettype wire

/* File: gps_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// display-clock enable divider plus cycle counter for strobe timing
module gps_timer
  import gps_pkg::*;
#(
  parameter int DIV = GPS_DISP_DIV
) (
  input  wire logic clk,
  input  wire logic rstn,
  gps_if.timer      tif
);
  typedef struct packed {
    logic [3:0] div;
    logic [4:0] count;
  } gps_tmr_s;
  gps_tmr_s s_q;
  gps_tmr_s s_d;
  always_comb
  begin
    s_d = s_q;
    if (tif.start || tif.clear)
    begin
      s_d.div   = 4'h0;
      s_d.count = 5'h00;
    end
    else
    begin
      // count is in system clocks; saturating keeps a long idle from wrapping
      if (s_q.count != 5'h1f)
        s_d.count = s_q.count + 5'h01;
      if (s_q.div == 4'(DIV - 1))
        s_d.div = 4'h0;
      else
        s_d.div = s_q.div + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  // enable pulse on the system clock edge that closes each display clock
  assign tif.tick  = (s_q.div == 4'(DIV - 1));
  assign tif.count = s_q.count;
endmodule // gps_timer
`default_nettype wire

/* File: gps_port.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_port
  import gps_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // configuration
  input  wire logic        pci_mode,
  input  wire logic        periph_other_en,
  input  wire logic [1:0]  pin_function_select,
  input  wire logic [7:0]  input_enable_register,
  // register writes
  input  wire logic        trigger_wr,
  input  wire logic [7:0]  trigger_wdata,
  input  wire logic        port_data_wr,
  input  wire logic [7:0]  port_data_wdata,
  // io read
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  // pins
  input  wire logic [7:0]  local_data_lines_in,
  input  wire logic [7:0]  system_data_bus_in,
  output logic      [3:0]  local_data_lines_out,
  output logic             local_data_lines_oe_n,
  output logic      [15:8] system_data_bus_out,
  output logic             system_data_bus_oe_n,
  output logic             local_write_strobe,
  output logic             port_strobe_n,
  output logic             pin_151,
  output logic             pin_190,
  output logic             pin_153,
  output logic             rom_pin_is_output,
  // status
  output logic      [7:0]  port_data_register,
  output logic      [7:0]  port_trigger_output_register,
  output logic      [7:0]  input_read_data,
  output logic             input_read_valid,
  output logic             busy
);
  gps_if tif ();
  gps_timer #(.DIV(GPS_DISP_DIV)) u_timer (.clk(clk), .rstn(rstn), .tif(tif));

  typedef struct packed {
    gps_state_e st;
    logic       rd;
    logic [7:0] data;
    logic [7:0] outr;
    logic [3:0] loc_out;
    logic       loc_oe_n;
    logic [7:0] sys_out;
    logic       sys_oe_n;
    logic       wstb;
    logic       pstr_n;
    logic       p151;
    logic       p190;
    logic       p153;
    logic       rom_out;
    logic [7:0] rdata;
    logic       rvalid;
    logic       busy;
  } gps_s;
  gps_s s_q;
  gps_s s_d;

  logic strobe_mode;
  logic pci_ok;
  logic in_rd;
  assign strobe_mode = (pin_function_select == GPS_SEL_STROBE);
  assign pci_ok      = pci_mode && !periph_other_en && strobe_mode;
  assign in_rd       = io_rd && io_addr == GPS_INPUT_PORT
                       && input_enable_register[GPS_IN_EN_BIT];

  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    tif.start  = 1'b0;
    tif.clear  = 1'b0;
    if (port_data_wr)
      s_d.data = port_data_wdata;
    if (trigger_wr)
      s_d.outr = trigger_wdata;
    case (s_q.st)
      GPS_IDLE:
      begin
        s_d.loc_oe_n = 1'b1;
        s_d.sys_oe_n = 1'b1;
        if (trigger_wr && pci_ok)
        begin
          s_d.st       = GPS_PCI;
          s_d.loc_out  = port_data_wr ? port_data_wdata[3:0] : s_q.data[3:0];
          s_d.loc_oe_n = 1'b0;
          s_d.wstb     = 1'b0;
          tif.start    = 1'b1;
        end
        else if (!pci_mode && strobe_mode && (trigger_wr || in_rd))
        begin
          s_d.st       = GPS_LOCAL;
          s_d.rd       = !trigger_wr;
          s_d.sys_out  = trigger_wdata;
          s_d.sys_oe_n = !trigger_wr;
          s_d.pstr_n   = 1'b0;
          tif.start    = 1'b1;
        end
      end
      GPS_PCI:
        // strobe low for two display clocks, rising edge samples the inputs
        if (tif.tick && tif.count == 5'(GPS_STROBE_TICKS * GPS_DISP_DIV - 1))
        begin
          s_d.st        = GPS_HOLD;
          s_d.wstb      = 1'b1;
          s_d.data[7:4] = local_data_lines_in[7:4];
        end
      GPS_HOLD:
        // half a display clock is one system clock at a divide of two
        begin
          s_d.st       = GPS_IDLE;
          s_d.loc_oe_n = 1'b1;
          tif.clear    = 1'b1;
        end
      GPS_LOCAL:
        if (s_q.rd ? (tif.count == 5'(GPS_IN_SCLKS)) : (tif.count == 5'(GPS_OUT_SCLKS)))
        begin
          // counts sit inside 6-8 and 18-20 system clocks
          s_d.st       = GPS_IDLE;
          s_d.pstr_n   = 1'b1;
          s_d.sys_oe_n = 1'b1;
          tif.clear    = 1'b1;
          if (s_q.rd)
          begin
            s_d.rdata  = system_data_bus_in;
            s_d.rvalid = 1'b1;
          end
        end
      default:
        s_d.st = GPS_IDLE;
    endcase
    // static pins; strobe modes own 151/190 only while the strobe is enabled
    s_d.rom_out = !pci_mode && pin_function_select == GPS_SEL_OUT2;
    s_d.p153    = s_d.rom_out ? s_d.outr[1] : 1'b1;
    if (pci_mode && pin_function_select[GPS_SEL_PCI_BIT])
    begin
      s_d.p151 = s_d.outr[0];
      s_d.p190 = s_d.outr[1];
    end
    else if (!pci_mode && pin_function_select[GPS_SEL_PCI_BIT])
    begin
      s_d.p151 = s_d.outr[0];
      s_d.p190 = 1'b1;
    end
    else
    begin
      s_d.p151 = 1'b1;
      s_d.p190 = 1'b1;
    end
    // kept as a flop so the busy output is glitch free
    s_d.busy = (s_d.st != GPS_IDLE);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q          <= '0;
      s_q.st       <= GPS_IDLE;
      s_q.data     <= GPS_DATA_RST;
      s_q.outr     <= GPS_OUT_RST;
      s_q.loc_oe_n <= 1'b1;
      s_q.sys_oe_n <= 1'b1;
      s_q.wstb     <= 1'b1;
      s_q.pstr_n   <= 1'b1;
      s_q.p151     <= 1'b1;
      s_q.p190     <= 1'b1;
      s_q.p153     <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign local_data_lines_out         = s_q.loc_out;
  assign local_data_lines_oe_n        = s_q.loc_oe_n;
  assign system_data_bus_out          = s_q.sys_out;
  assign system_data_bus_oe_n         = s_q.sys_oe_n;
  assign local_write_strobe           = s_q.wstb;
  assign port_strobe_n                = s_q.pstr_n;
  assign pin_151                      = s_q.p151;
  assign pin_190                      = s_q.p190;
  assign pin_153                      = s_q.p153;
  assign rom_pin_is_output            = s_q.rom_out;
  assign port_data_register           = s_q.data;
  assign port_trigger_output_register = s_q.outr;
  assign input_read_data              = s_q.rdata;
  assign input_read_valid             = s_q.rvalid;
  assign busy                         = s_q.busy;
endmodule // gps_port
`default_nettype wire

/* File: gps_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_port_assertions
  import gps_pkg::*;
(
  // configuration and requests
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        pci_mode,
  input wire logic        periph_other_en,
  input wire logic [1:0]  pin_function_select,
  input wire logic [7:0]  input_enable_register,
  input wire logic        trigger_wr,
  input wire logic        io_rd,
  input wire logic [15:0] io_addr,
  // pins and status
  input wire logic        local_data_lines_oe_n,
  input wire logic        system_data_bus_oe_n,
  input wire logic        local_write_strobe,
  input wire logic        port_strobe_n,
  input wire logic        pin_151,
  input wire logic        pin_190,
  input wire logic        pin_153,
  input wire logic [7:0]  port_trigger_output_register,
  input wire logic        input_read_valid,
  input wire logic        busy
);
  wire logic [1:0] sel = pin_function_select;
  wire logic [7:0] r   = port_trigger_output_register;
  wire logic       go  = !busy && sel == GPS_SEL_STROBE;
  wire logic       pgo = go && trigger_wr && pci_mode && !periph_other_en;
  wire logic       lwr = go && trigger_wr && !pci_mode;
  wire logic       lrd = go && io_rd && !pci_mode && io_addr == GPS_INPUT_PORT
                         && input_enable_register[GPS_IN_EN_BIT];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  chk_pci_start: assert property (pgo |=> !local_write_strobe && !local_data_lines_oe_n)
    else $error("pci transfer did not start");
  chk_strobe_len: assert property ($fell(local_write_strobe) |->
    !local_write_strobe[*4] ##1 local_write_strobe) else $error("strobe width wrong");
  chk_data_hold: assert property ($rose(local_write_strobe) |->
    !local_data_lines_oe_n ##1 local_data_lines_oe_n) else $error("data hold wrong");
  chk_pci_pins: assert property ((pci_mode && sel[1] && !trigger_wr)[*3] |->
    pin_151 == r[0] && pin_190 == r[1]) else $error("pci static pins wrong");
  chk_two_pins: assert property ((!pci_mode && sel == GPS_SEL_OUT2 && !trigger_wr)[*3] |->
    pin_151 == r[0] && pin_153 == r[1]) else $error("two pin output wrong");
  chk_one_pin: assert property ((!pci_mode && sel == GPS_SEL_OUT1 && !trigger_wr)[*3] |->
    pin_151 == r[0] && pin_153) else $error("one pin output wrong");
  chk_out_span: assert property (lwr |=> !port_strobe_n[*8] ##1 port_strobe_n)
    else $error("output cycle length wrong");
  chk_bus_drive: assert property (lwr |=> !system_data_bus_oe_n[*8] ##1 system_data_bus_oe_n)
    else $error("upper byte drive window wrong");
  chk_in_span: assert property (lrd |-> ##[17:23] input_read_valid)
    else $error("input cycle length wrong");
endmodule // gps_port_assertions
bind gps_port gps_port_assertions u_gps_port_assertions (.*);
`default_nettype wire

/* File: gps_ext.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_ext (
  // from the block; rd and offer from the bench
  input  wire logic       port_strobe_n,
  input  wire logic       local_write_strobe,
  input  wire logic       rd,
  input  wire logic [7:0] upper_byte,
  input  wire logic [3:0] out_nibble,
  input  wire logic [7:0] offer,
  // to the block and bench
  output logic      [7:0] lower_byte,
  output logic      [3:0] pci_q,
  output logic      [7:0] lat_q
);
  // released bus shows the inverse so a stale byte cannot pass
  assign lower_byte = (!port_strobe_n && rd) ? offer : ~offer;
  always @(posedge local_write_strobe) pci_q <= out_nibble;
  always @(posedge port_strobe_n) if (!rd) lat_q <= upper_byte;
endmodule // gps_ext
`default_nettype wire

/* File: gps_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_port_tb;
  import gps_pkg::*;
  logic        clk, rstn, pci_mode, periph_other_en, trigger_wr, port_data_wr, io_rd, rd;
  logic        local_data_lines_oe_n, system_data_bus_oe_n, local_write_strobe, busy;
  logic        port_strobe_n, pin_151, pin_190, pin_153, rom_pin_is_output, input_read_valid;
  logic [1:0]  pin_function_select;
  logic [3:0]  local_data_lines_out, pq;
  logic [15:8] system_data_bus_out;
  logic [15:0] io_addr;
  logic [7:0]  input_enable_register, trigger_wdata, port_data_wdata, system_data_bus_in;
  logic [7:0]  port_data_register, port_trigger_output_register, input_read_data;
  logic [7:0]  local_data_lines_in, lq, off, v;
  int          err_count, tests_run;
  assign local_data_lines_in = off;
  gps_port u_gps_port (.*);
  gps_ext u_gps_ext (.port_strobe_n, .local_write_strobe, .rd, .upper_byte(system_data_bus_out),
    .out_nibble(local_data_lines_out), .offer(off), .lower_byte(system_data_bus_in), .pci_q(pq),
    .lat_q(lq));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [1:0] pins_exp(input logic m, input int s, input logic [7:0] r);
    return (m || s == 3) ? r[1:0] : {1'b1, r[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic trig(input logic [7:0] d);
    @(negedge clk);
    trigger_wr = 1'b1;
    trigger_wdata = d;
    @(negedge clk);
    trigger_wr = 1'b0;
    repeat (40) if (busy !== 1'b0) @(negedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim;
  end
  initial
  begin
    {rstn, pci_mode, periph_other_en, trigger_wr, port_data_wr, io_rd, rd} = '0;
    {pin_function_select, input_enable_register, trigger_wdata, port_data_wdata} = '0;
    io_addr = 16'h0000;
    v = 8'h2a;
    off = 8'h00;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    chk("reset pins", 8'h07, {5'h00, pin_151, pin_190, pin_153});
    {pci_mode, pin_function_select} = {1'b1, GPS_SEL_STROBE};
    repeat (4)
    begin
      v = lfsr(v);
      off = lfsr(v);
      @(negedge clk);
      {port_data_wr, port_data_wdata} = {1'b1, v};
      @(negedge clk);
      port_data_wr = 1'b0;
      trig(v);
      chk("pci nibble", {4'h0, v[3:0]}, {4'h0, pq});
      chk("pci data", {off[7:4], v[3:0]}, port_data_register);
    end
    periph_other_en = 1'b1;
    off = ~off;
    trig(v);
    chk("refused", {~off[7:4], v[3:0]}, port_data_register);
    periph_other_en = 1'b0;
    $display("pci port test done");
    for (int m = 1; m >= 0; m--)
      for (int s = 2; s < 4; s++)
      begin
        {pci_mode, pin_function_select} = {m[0], s[1:0]};
        v = lfsr(v);
        trig(v);
        // three settled cycles so the static pin assertions see their window
        repeat (3) @(negedge clk);
        chk("pins", {6'h00, pins_exp(m[0], s, v)},
          {6'h00, m[0] ? pin_190 : pin_153, pin_151});
        chk("rom pin", {7'h00, !m[0] && s == 3}, {7'h00, rom_pin_is_output});
      end
    $display("static pin test done");
    pin_function_select = GPS_SEL_STROBE;
    v = lfsr(v);
    trig(v);
    chk("latch", v, lq);
    rd = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      input_enable_register = k == 1 ? 8'h00 : 8'h04;
      io_addr = k == 2 ? 16'h03c9 : GPS_INPUT_PORT;
      off = lfsr(off);
      @(negedge clk);
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      repeat (30) if (input_read_valid !== 1'b1) @(negedge clk);
      chk("read valid", {7'h00, k == 0}, {7'h00, input_read_valid});
      if (k == 0) chk("read byte", off, input_read_data);
    end
    $display("local port test done");
    end_sim;
  end
endmodule // gps_port_tb
`default_nettype wire
